// ===== verilog/radio_decode_pkg.sv
// Operation
// - Highpass pin high forces 600 kHz; else field 00/X1/10 = 100/4k/30k Hz.
// - Bits 11:10 at address 1111 set receiver output common-mode level.
// - Bits 9:8 at 1000 route indicator; gate 0 with highpass low means off.
// - Signal-strength indicator is on only in receive mode, off in transmit.
// - Transmitter on only with receive/transmit pin high and chip-on high.
// - Bits 1:0 at 1000 select transmit lowpass coarse 8/11/16.5/22.5 MHz.
// - Bits 5:3 at 0111 select transmit fine trim 90 to 115 percent.
// - Transmit gain comes from six-bit field at bits 5:0 of address 1100.
// - Bit 10 at 1001: 0 uses parallel gain pins, 1 uses serial field.
// - Receiver enabled only with receive/transmit pin low and chip-on high.
// - Same coarse field also sets receive lowpass 7.5/8.5/15/18 MHz.
// - Gain code all ones is maximum output; all zeros is 31 dB below.
package radio_decode_pkg;
  // Serial word layout
  localparam int DATA_W = 14;
  localparam int ADDR_W = 4;
  localparam int WORD_BITS = DATA_W + ADDR_W;
  localparam int GAIN_W = 6;
  // Register addresses
  localparam logic [3:0] ADDR_FILTER_PROGRAMMING = 4'h7;
  localparam logic [3:0] ADDR_MODE_AND_INDICATOR = 4'h8;
  localparam logic [3:0] ADDR_GAIN_SOURCE = 4'h9;
  localparam logic [3:0] ADDR_TRANSMIT_GAIN = 4'hc;
  localparam logic [3:0] ADDR_OUTPUT_COMMON_MODE = 4'hf;
  // Field positions
  localparam int HP_FIELD_LSB = 12;
  localparam int FINE_FIELD_LSB = 3;
  localparam int COARSE_FIELD_LSB = 0;
  localparam int IND_SEL_LSB = 8;
  localparam int IND_GATE_BIT = 10;
  localparam int GAIN_SRC_BIT = 10;
  localparam int GAIN_FIELD_LSB = 0;
  localparam int CM_FIELD_LSB = 10;
  // Values after reset
  localparam logic [1:0] HP_FIELD_RESET = 2'h0;
  localparam logic [2:0] FINE_RESET = 3'h2;
  localparam logic [1:0] COARSE_RESET = 2'h1;
  localparam logic [1:0] IND_SEL_RESET = 2'h0;
  localparam logic IND_GATE_RESET = 1'b0;
  localparam logic GAIN_SRC_RESET = 1'b0;
  localparam logic [5:0] GAIN_RESET = 6'h00;
  localparam logic [1:0] CM_RESET = 2'h0;
  // Highpass corner select codes
  localparam logic [1:0] HP_CORNER_100 = 2'h0;
  localparam logic [1:0] HP_CORNER_4K = 2'h1;
  localparam logic [1:0] HP_CORNER_30K = 2'h2;
  localparam logic [1:0] HP_CORNER_600K = 2'h3;
  // Indicator route codes
  localparam logic [1:0] IND_OFF = 2'h0;
  localparam logic [1:0] IND_SIGNAL = 2'h1;
  localparam logic [1:0] IND_TEMPERATURE = 2'h2;
  localparam logic [1:0] IND_POWER = 2'h3;
  // Select field values
  localparam logic [1:0] IND_SEL_SIGNAL = 2'h0;
  localparam logic [1:0] IND_SEL_TEMPERATURE = 2'h1;
  localparam logic [1:0] IND_SEL_POWER = 2'h2;
  localparam logic [1:0] IND_SEL_UNUSED = 2'h3;
  localparam logic [2:0] FINE_LAST_USED = 3'h5;
endpackage

// ===== verilog/serial_write_if.sv
`timescale 1ns/10ps
`default_nettype none
interface serial_write_if;
  logic wr_valid;
  logic [radio_decode_pkg::ADDR_W-1:0] wr_addr;
  logic [radio_decode_pkg::DATA_W-1:0] wr_data;
  modport source (output wr_valid, output wr_addr, output wr_data);
  modport sink (input wr_valid, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// ===== verilog/serial_write_port.sv
`timescale 1ns/10ps
`default_nettype none
module serial_write_port #(
  parameter int WORD_BITS = radio_decode_pkg::WORD_BITS
) (
  // Clock and control
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Serial pins
  input wire logic serial_select_n,
  input wire logic serial_clock,
  input wire logic serial_data,
  // Decoded writes
  serial_write_if.source wr
);
  localparam int AW = radio_decode_pkg::ADDR_W;

  // Refuse a word length the bit counter and field split cannot serve
  if (WORD_BITS != radio_decode_pkg::WORD_BITS) begin : g_word_check
    $error("serial word length must equal data plus address width");
  end

  logic sel_s1, sel_s2, sel_d;
  logic sck_s1, sck_s2, sck_d;
  logic din_s1, din_s2;
  logic [WORD_BITS-1:0] shift;
  logic [4:0] count;

  // Edge detect on second synchroniser stage only
  wire sck_rise = sck_s2 & ~sck_d;
  wire sel_rise = sel_s2 & ~sel_d;
  wire word_ok = (count == 5'(WORD_BITS));
  wire count_full = (count == 5'h1f);

  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {sel_s1, sel_s2, sel_d} <= 3'h7;
      {sck_s1, sck_s2, sck_d} <= 3'h0;
      {din_s1, din_s2} <= 2'h0;
    end else if (ce) begin
      {sel_s1, sel_s2, sel_d} <= {serial_select_n, sel_s1, sel_s2};
      {sck_s1, sck_s2, sck_d} <= {serial_clock, sck_s1, sck_s2};
      {din_s1, din_s2} <= {serial_data, din_s1};
    end
  end

  // Shift in while selected, count bits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift <= '0;
      count <= 5'h0;
    end else if (ce) begin
      if (sel_s2) begin
        count <= 5'h0;
      end else if (sck_rise) begin
        shift <= {shift[WORD_BITS-2:0], din_s2};
        count <= count_full ? count : count + 5'h1;
      end
    end
  end

  // Write strobe on deselect, only for a whole word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr.wr_valid <= 1'b0;
      wr.wr_addr <= '0;
      wr.wr_data <= '0;
    end else if (ce) begin
      wr.wr_valid <= sel_rise & word_ok;
      if (sel_rise & word_ok) begin
        wr.wr_addr <= shift[AW-1:0];
        wr.wr_data <= shift[WORD_BITS-1:AW];
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/radio_analog_control_decode.sv
`timescale 1ns/10ps
`default_nettype none
module radio_analog_control_decode #(
  parameter int GAIN_W = radio_decode_pkg::GAIN_W
) (
  // Clock and control
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Serial write pins
  input wire logic serial_select_n,
  input wire logic serial_clock,
  input wire logic serial_data,
  // Parallel control pins
  input wire logic highpass_select_pin,
  input wire logic receive_transmit_select_pin,
  input wire logic chip_on_pin,
  input wire logic [GAIN_W-1:0] parallel_gain_pins,
  // Analog select codes
  output logic [1:0] highpass_corner,
  output logic [1:0] common_mode_level,
  output logic [1:0] indicator_route,
  output logic [1:0] tx_lowpass_coarse,
  output logic [1:0] rx_lowpass_coarse,
  output logic [2:0] tx_lowpass_fine,
  output logic [GAIN_W-1:0] tx_gain,
  output logic tx_enable,
  output logic rx_enable
);
  localparam int DW = radio_decode_pkg::DATA_W;

  // Refuse a gain width the field layout cannot hold
  if (GAIN_W != radio_decode_pkg::GAIN_W) begin : g_gain_width_check
    $error("transmit gain width must be six");
  end

  // True when a write strobe targets the given address
  function automatic logic hit(input logic valid, input logic [3:0] addr,
                               input logic [3:0] target);
    hit = valid && (addr == target);
  endfunction

  serial_write_if wr_bus ();

  serial_write_port #(
    .WORD_BITS(radio_decode_pkg::WORD_BITS)
  ) u_port (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .serial_select_n(serial_select_n),
    .serial_clock(serial_clock),
    .serial_data(serial_data),
    .wr(wr_bus.source)
  );

  // Stored fields
  logic [1:0] hp_field;
  logic [2:0] fine_field;
  logic [1:0] coarse_field;
  logic [1:0] ind_sel;
  logic ind_gate;
  logic gain_src_serial;
  logic [GAIN_W-1:0] gain_field;
  logic [1:0] cm_field;

  // Pin synchronisers
  logic [GAIN_W+2:0] pin_s1, pin_s2;

  // Write decode
  wire [DW-1:0] wd = wr_bus.wr_data;
  wire wr_filter = hit(wr_bus.wr_valid, wr_bus.wr_addr,
                       radio_decode_pkg::ADDR_FILTER_PROGRAMMING);
  wire wr_mode = hit(wr_bus.wr_valid, wr_bus.wr_addr,
                     radio_decode_pkg::ADDR_MODE_AND_INDICATOR);
  wire wr_src = hit(wr_bus.wr_valid, wr_bus.wr_addr,
                    radio_decode_pkg::ADDR_GAIN_SOURCE);
  wire wr_gain = hit(wr_bus.wr_valid, wr_bus.wr_addr,
                     radio_decode_pkg::ADDR_TRANSMIT_GAIN);
  wire wr_cm = hit(wr_bus.wr_valid, wr_bus.wr_addr,
                   radio_decode_pkg::ADDR_OUTPUT_COMMON_MODE);
  wire [1:0] wd_hp = wd[radio_decode_pkg::HP_FIELD_LSB +: 2];
  wire [2:0] wd_fine = wd[radio_decode_pkg::FINE_FIELD_LSB +: 3];
  wire [1:0] wd_coarse = wd[radio_decode_pkg::COARSE_FIELD_LSB +: 2];
  wire [1:0] wd_ind = wd[radio_decode_pkg::IND_SEL_LSB +: 2];
  wire fine_used = (wd_fine <= radio_decode_pkg::FINE_LAST_USED);
  wire ind_used = (wd_ind != radio_decode_pkg::IND_SEL_UNUSED);

  // Filter programming register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hp_field <= radio_decode_pkg::HP_FIELD_RESET;
      fine_field <= radio_decode_pkg::FINE_RESET;
    end else if (ce && wr_filter) begin
      hp_field <= wd_hp;
      if (fine_used) begin
        fine_field <= wd_fine;
      end
    end
  end

  // Mode and indicator register; coarse code serves both paths
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      coarse_field <= radio_decode_pkg::COARSE_RESET;
      ind_sel <= radio_decode_pkg::IND_SEL_RESET;
      ind_gate <= radio_decode_pkg::IND_GATE_RESET;
    end else if (ce && wr_mode) begin
      coarse_field <= wd_coarse;
      ind_gate <= wd[radio_decode_pkg::IND_GATE_BIT];
      if (ind_used) begin
        ind_sel <= wd_ind;
      end
    end
  end

  // Gain source register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gain_src_serial <= radio_decode_pkg::GAIN_SRC_RESET;
    end else if (ce && wr_src) begin
      gain_src_serial <= wd[radio_decode_pkg::GAIN_SRC_BIT];
    end
  end

  // Serial gain field, kept even while the pins rule
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gain_field <= radio_decode_pkg::GAIN_RESET;
    end else if (ce && wr_gain) begin
      gain_field <= wd[radio_decode_pkg::GAIN_FIELD_LSB +: GAIN_W];
    end
  end

  // Output common-mode register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cm_field <= radio_decode_pkg::CM_RESET;
    end else if (ce && wr_cm) begin
      cm_field <= wd[radio_decode_pkg::CM_FIELD_LSB +: 2];
    end
  end

  // Two-stage synchronisers for the parallel pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else if (ce) begin
      pin_s1 <= {highpass_select_pin, receive_transmit_select_pin,
                 chip_on_pin, parallel_gain_pins};
      pin_s2 <= pin_s1;
    end
  end

  wire hp_pin = pin_s2[GAIN_W+2];
  wire rt_pin = pin_s2[GAIN_W+1];
  wire on_pin = pin_s2[GAIN_W];
  wire [GAIN_W-1:0] gain_pins = pin_s2[GAIN_W-1:0];

  // Mode decode
  wire next_tx_enable = rt_pin & on_pin;
  wire next_rx_enable = ~rt_pin & on_pin;

  // Highpass corner decode
  wire [1:0] hp_near = hp_field[0] ? radio_decode_pkg::HP_CORNER_4K :
                       hp_field[1] ? radio_decode_pkg::HP_CORNER_30K :
                       radio_decode_pkg::HP_CORNER_100;
  wire [1:0] next_highpass = hp_pin ? radio_decode_pkg::HP_CORNER_600K :
                             hp_near;

  // Indicator route decode
  wire ind_open = ind_gate | hp_pin;
  wire [1:0] ind_pick =
    (ind_sel == radio_decode_pkg::IND_SEL_TEMPERATURE) ?
      radio_decode_pkg::IND_TEMPERATURE :
    (ind_sel == radio_decode_pkg::IND_SEL_POWER) ?
      radio_decode_pkg::IND_POWER :
    next_rx_enable ? radio_decode_pkg::IND_SIGNAL :
      radio_decode_pkg::IND_OFF;
  wire [1:0] next_indicator = ind_open ? ind_pick :
                              radio_decode_pkg::IND_OFF;

  // Gain source select; all ones is maximum output
  wire [GAIN_W-1:0] next_gain = gain_src_serial ? gain_field :
                                gain_pins;

  // Registered mode enables and receive path codes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
      highpass_corner <= radio_decode_pkg::HP_CORNER_100;
      common_mode_level <= radio_decode_pkg::CM_RESET;
    end else if (ce) begin
      tx_enable <= next_tx_enable;
      rx_enable <= next_rx_enable;
      highpass_corner <= next_highpass;
      common_mode_level <= cm_field;
    end
  end

  // Registered lowpass corner codes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_lowpass_coarse <= radio_decode_pkg::COARSE_RESET;
      rx_lowpass_coarse <= radio_decode_pkg::COARSE_RESET;
      tx_lowpass_fine <= radio_decode_pkg::FINE_RESET;
    end else if (ce) begin
      tx_lowpass_coarse <= coarse_field;
      rx_lowpass_coarse <= coarse_field;
      tx_lowpass_fine <= fine_field;
    end
  end

  // Registered indicator route and transmit gain
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      indicator_route <= radio_decode_pkg::IND_OFF;
      tx_gain <= radio_decode_pkg::GAIN_RESET;
    end else if (ce) begin
      indicator_route <= next_indicator;
      tx_gain <= next_gain;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/none_placeholder_removed.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== verif/decode_checker.sv
`timescale 1ns/10ps
`default_nettype none
module decode_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins
  input wire logic serial_select_n,
  input wire logic highpass_select_pin,
  input wire logic receive_transmit_select_pin,
  input wire logic chip_on_pin,
  // Select codes
  input wire logic [1:0] highpass_corner,
  input wire logic [1:0] common_mode_level,
  input wire logic [1:0] indicator_route,
  input wire logic [1:0] tx_lowpass_coarse,
  input wire logic [1:0] rx_lowpass_coarse,
  input wire logic [2:0] tx_lowpass_fine,
  input wire logic tx_enable,
  input wire logic rx_enable
);
  // Mode decode of the raw pins
  wire logic tx_on = receive_transmit_select_pin && chip_on_pin;
  wire logic rx_on = !receive_transmit_select_pin && chip_on_pin;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Pins settle through two syncs and one register
  property p_tx_on;
    tx_on[*4] |-> tx_enable && !rx_enable;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx enable wrong");
  property p_rx_on;
    rx_on[*4] |-> rx_enable && !tx_enable;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("rx enable wrong");
  property p_off;
    (!chip_on_pin)[*4] |-> !tx_enable && !rx_enable;
  endproperty
  a_off: assert property (p_off) else $error("enable while off");
  property p_hp;
    highpass_select_pin[*4] |-> highpass_corner == 2'h3;
  endproperty
  a_hp: assert property (p_hp) else $error("highpass not forced");
  property p_sig;
    (!rx_on)[*4] |-> indicator_route != 2'h1;
  endproperty
  a_sig: assert property (p_sig) else $error("strength outside rx");
  property p_pair;
    tx_lowpass_coarse == rx_lowpass_coarse;
  endproperty
  a_pair: assert property (p_pair) else $error("coarse differ");
  property p_fine;
    tx_lowpass_fine <= 3'h5;
  endproperty
  a_fine: assert property (p_fine) else $error("unused fine code");
  // Register fields move only after a completed frame
  property p_cm;
    $changed(common_mode_level) |-> $past(serial_select_n, 3);
  endproperty
  a_cm: assert property (p_cm) else $error("cm moved in frame");
endmodule
bind radio_analog_control_decode decode_checker u_decode_checker (
  .clock(clock), .rst_n(rst_n), .serial_select_n(serial_select_n),
  .highpass_select_pin(highpass_select_pin),
  .receive_transmit_select_pin(receive_transmit_select_pin),
  .chip_on_pin(chip_on_pin), .highpass_corner(highpass_corner),
  .common_mode_level(common_mode_level),
  .indicator_route(indicator_route),
  .tx_lowpass_coarse(tx_lowpass_coarse),
  .rx_lowpass_coarse(rx_lowpass_coarse),
  .tx_lowpass_fine(tx_lowpass_fine), .tx_enable(tx_enable),
  .rx_enable(rx_enable)
);
`default_nettype wire

// ===== verif/baseband.sv
`timescale 1ns/10ps
`default_nettype none
module baseband (
  // Clock
  input wire logic clock,
  // Serial pins
  output logic serial_select_n,
  output logic serial_clock,
  output logic serial_data,
  // Control pins
  output logic highpass_select_pin,
  output logic receive_transmit_select_pin,
  output logic chip_on_pin,
  output logic [5:0] parallel_gain_pins
);
  // Idle pins at time zero
  initial begin
    serial_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data = 1'b0;
    pins(1'b0, 1'b0, 1'b0, 6'h00);
  end
  // Waits on falling edges so pins move off the sampling edge
  task gap(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Sends the top n bits of a word, MSB first, slow clock
  task send(input int n, input logic [17:0] w);
    int i;
    serial_select_n = 1'b0;
    for (i = 17; i > 17 - n; i--) begin
      serial_data = w[i];
      gap(3);
      serial_clock = 1'b1;
      gap(3);
      serial_clock = 1'b0;
    end
    gap(3);
    serial_select_n = 1'b1;
    serial_data = ~serial_data; // Released line shows no stale bit
    gap(12);
  endtask
  // Sets the mode pins and the parallel gain code
  task pins(input logic hp, rt, on, input logic [5:0] g);
    highpass_select_pin = hp;
    receive_transmit_select_pin = rt;
    chip_on_pin = on;
    parallel_gain_pins = g;
    gap(5);
  endtask
endmodule
`default_nettype wire

// ===== verif/radio_analog_control_decode_bench.sv
`timescale 1ns/10ps
`default_nettype none
module radio_analog_control_decode_bench;
  logic clock, rst_n, ce;
  wire logic ssn, sck, sd, hp, rt, on;
  wire logic [5:0] pg, tg;
  wire logic [1:0] hc, cm, ir, tc, rc;
  wire logic [2:0] tf;
  wire logic te, re;
  int n_fail, n_compared, cycles;
  baseband u_baseband (.clock(clock), .serial_select_n(ssn),
    .serial_clock(sck), .serial_data(sd), .highpass_select_pin(hp),
    .receive_transmit_select_pin(rt), .chip_on_pin(on),
    .parallel_gain_pins(pg));
  radio_analog_control_decode u_radio_analog_control_decode (
    .clock(clock), .rst_n(rst_n), .ce(ce), .serial_select_n(ssn),
    .serial_clock(sck), .serial_data(sd), .highpass_select_pin(hp),
    .receive_transmit_select_pin(rt), .chip_on_pin(on),
    .parallel_gain_pins(pg), .highpass_corner(hc),
    .common_mode_level(cm), .indicator_route(ir),
    .tx_lowpass_coarse(tc), .rx_lowpass_coarse(rc),
    .tx_lowpass_fine(tf), .tx_gain(tg), .tx_enable(te),
    .rx_enable(re));
  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      n_fail++;
      final_report();
    end
  end
  task final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [5:0] got, input logic [5:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [13:0] d);
    u_baseband.send(18, {d, a});
  endtask
  // Main sequence
  initial begin
    int i;
    logic [1:0] c;
    rst_n = 1'b0;
    ce = 1'b1;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    u_baseband.gap(2);
    chk({hc, cm, ir}, 6'h00);
    chk({tc, 1'b0, tf}, 6'h12);
    chk({te, re, 4'h0}, 6'h00);
    for (i = 0; i < 4; i++) begin
      wr(4'hf, 14'(i << 10));
      chk({4'h0, cm}, 6'(i));
    end
    for (i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(4'h8, 14'h500 | 14'(i));
      chk({tc, rc, ir}, {c, c, 2'h2});
    end
    for (i = 0; i < 8; i++) begin
      c = 2'(i);
      wr(4'h7, 14'(i << 12) | 14'(i << 3));
      chk({hc, 1'b0, tf}, {(c[0] ? 2'h1 : c), 1'b0,
        (i > 5 ? 3'h5 : 3'(i))});
    end
    u_baseband.pins(1'b1, 1'b0, 1'b0, 6'h00);
    chk({4'h0, hc}, 6'h03);
    u_baseband.pins(1'b0, 1'b0, 1'b1, 6'h00);
    wr(4'h8, 14'h200);
    chk({4'h0, ir}, 6'h00);
    u_baseband.pins(1'b1, 1'b0, 1'b1, 6'h00);
    chk({4'h0, ir}, 6'h03);
    wr(4'h8, 14'h300);
    chk({4'h0, ir}, 6'h03);
    u_baseband.pins(1'b0, 1'b0, 1'b1, 6'h00);
    wr(4'h8, 14'h400);
    chk({te, re, 2'h0, ir}, 6'h11);
    u_baseband.pins(1'b0, 1'b1, 1'b1, 6'h00);
    chk({te, re, 2'h0, ir}, 6'h20);
    u_baseband.pins(1'b0, 1'b1, 1'b0, 6'h2a);
    chk({te, re, 4'h0}, 6'h00);
    chk(tg, 6'h2a);
    wr(4'hc, 14'h0015);
    chk(tg, 6'h2a);
    wr(4'h9, 14'h400);
    chk(tg, 6'h15);
    u_baseband.pins(1'b0, 1'b1, 1'b0, 6'h07);
    chk(tg, 6'h15);
    wr(4'hc, 14'h003f);
    chk(tg, 6'h3f);
    wr(4'hc, 14'h0000);
    chk(tg, 6'h00);
    // Short frame must be dropped
    u_baseband.send(17, {14'h0000, 4'hf});
    chk({4'h0, cm}, 6'h03);
    // Frame sent while frozen must be lost
    ce = 1'b0;
    wr(4'hf, 14'h0000);
    ce = 1'b1;
    u_baseband.gap(8);
    chk({4'h0, cm}, 6'h03);
    // Unknown address leaves the common-mode and coarse fields alone
    wr(4'ha, 14'h0000);
    chk({2'h0, cm, tc}, 6'h0c);
    final_report();
  end
endmodule
`default_nettype wire
